// [rtl/audio_tx_fifo_status.sv]
// Transmit FIFO status register with error flags, level flags, interrupt and DMA request
`timescale 1ns/1ps
module audio_tx_fifo_status #(
	parameter int DEPTH = tx_status_pkg::FIFO_DEPTH
) (
	input  wire logic                     core_clk_in,
	input  wire logic                     reset_in,
	input  wire tx_status_pkg::reg_access_t reg_in,
	input  wire logic                     fifo_write_in,
	input  wire logic                     fifo_full_in,
	input  wire logic [4:0]               fifo_level_in,
	input  wire logic                     sample_request_in,
	input  wire logic [31:0]              tx_control_reg_in,
	output logic [31:0]                   tx_fifo_status_out,
	output logic                          overflow_irq_out,
	output logic                          dma_request_out
);

	// Elaboration check: level and threshold logic is five bits wide
	if (DEPTH < 1 || DEPTH > 16)
	begin : g_depth_check
		$error("DEPTH must be 1 to 16");
	end

	// Host write to the status word with a one at the given bit
	function automatic logic clears_bit(
		input tx_status_pkg::reg_access_t acc,
		input int                         pos
	);
		return acc.sel && acc.write && acc.addr == tx_status_pkg::STATUS_OFFSET
			&& acc.wdata[pos];
	endfunction

	logic       overflow;
	logic       starve;
	logic       low_level;
	logic       drained;
	logic       next_low_level;
	logic       next_drained;
	logic       clear_hit;
	logic [4:0] free_entries;
	logic [4:0] thresh;
	logic       fifo_en;
	logic       overflow_event;
	logic       starve_event;
	logic       clear_overflow;
	logic       clear_starve;

	// Decode of control and FIFO state
	always_comb
	begin
		fifo_en = tx_control_reg_in[tx_status_pkg::CTRL_FIFO_EN];
		clear_hit = reg_in.sel && reg_in.write && reg_in.addr == tx_status_pkg::STATUS_OFFSET;
		clear_overflow = clears_bit(reg_in, tx_status_pkg::OVERFLOW_BIT);
		clear_starve = clears_bit(reg_in, tx_status_pkg::STARVE_BIT);
		overflow_event = fifo_write_in && fifo_en && fifo_full_in;
		starve_event = sample_request_in && fifo_en && fifo_level_in == 5'h00;
		free_entries = 5'(DEPTH) - fifo_level_in;
		thresh = {1'b0, tx_control_reg_in[tx_status_pkg::CTRL_THRESH_MSB:
			tx_status_pkg::CTRL_THRESH_LSB]};
		if (thresh == 5'h00)
			thresh = 5'h10; // Zero code means sixteen
		next_low_level = free_entries >= thresh;
		next_drained = fifo_level_in == 5'h00;
	end

	// Overflow flag, set beats clear
	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
			overflow <= 1'b0;
		else if (overflow_event)
			overflow <= 1'b1;
		else if (clear_overflow)
			overflow <= 1'b0;
	end

	// Starvation flag, set beats clear
	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
			starve <= 1'b0;
		else if (starve_event)
			starve <= 1'b1;
		else if (clear_starve)
			starve <= 1'b0;
	end

	// Registered level flags
	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			low_level <= 1'b1;
			drained <= 1'b1;
		end
		else
		begin
			low_level <= next_low_level;
			drained <= next_drained;
		end
	end

	// Status word and side outputs, one cycle after the flags
	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			tx_fifo_status_out <= tx_status_pkg::STATUS_RESET;
			overflow_irq_out <= 1'b0;
			dma_request_out <= 1'b0;
		end
		else
		begin
			tx_fifo_status_out <= {28'h0000000, overflow, starve, low_level, drained};
			overflow_irq_out <= overflow && tx_control_reg_in[tx_status_pkg::CTRL_OVER_IE];
			dma_request_out <= low_level && tx_control_reg_in[tx_status_pkg::CTRL_DMA_EN];
		end
	end

	// Overflow rises the cycle after a write into a full, enabled FIFO
	AST_OVERFLOW_SET: assert property (@(posedge core_clk_in) disable iff (reset_in)
		overflow_event |=> overflow)
		else $error("overflow flag not set");

	// Overflow never rises without its event
	AST_OVERFLOW_CAUSE: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!overflow && !overflow_event |=> !overflow)
		else $error("overflow flag set without cause");

	// Overflow holds until a one lands on its bit
	AST_OVERFLOW_HOLD: assert property (@(posedge core_clk_in) disable iff (reset_in)
		overflow && !clear_overflow |=> overflow)
		else $error("overflow flag dropped without clear");

	// A one on the overflow bit clears it, and the status word follows
	AST_OVERFLOW_CLEAR: assert property (@(posedge core_clk_in) disable iff (reset_in)
		clear_overflow && !overflow_event
		|=> !overflow ##1 !tx_fifo_status_out[tx_status_pkg::OVERFLOW_BIT])
		else $error("overflow flag not cleared");

	// A zero on the overflow bit leaves a set flag alone
	AST_ZERO_WRITE: assert property (@(posedge core_clk_in) disable iff (reset_in)
		clear_hit && !reg_in.wdata[tx_status_pkg::OVERFLOW_BIT] && overflow |=> overflow)
		else $error("zero write disturbed overflow flag");

	// Starvation rises after a request on an empty, enabled FIFO; set beats clear
	AST_STARVE_SET: assert property (@(posedge core_clk_in) disable iff (reset_in)
		starve_event |=> starve)
		else $error("starvation flag not set");

	// Starvation never rises without its event
	AST_STARVE_CAUSE: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!starve && !starve_event |=> !starve)
		else $error("starvation flag set without cause");

	// Starvation holds until a one lands on its bit
	AST_STARVE_HOLD: assert property (@(posedge core_clk_in) disable iff (reset_in)
		starve && !clear_starve |=> starve)
		else $error("starvation flag dropped without clear");

	// A one on the starvation bit clears it, and the status word follows
	AST_STARVE_CLEAR: assert property (@(posedge core_clk_in) disable iff (reset_in)
		clear_starve && !starve_event
		|=> !starve ##1 !tx_fifo_status_out[tx_status_pkg::STARVE_BIT])
		else $error("starvation flag not cleared");

	// Low-level flag rises when free entries meet the threshold
	AST_LOW_LEVEL: assert property (@(posedge core_clk_in) disable iff (reset_in)
		free_entries >= thresh |=> low_level)
		else $error("low-level flag missing");

	// Low-level flag falls when free entries are below the threshold
	AST_LOW_LEVEL_OFF: assert property (@(posedge core_clk_in) disable iff (reset_in)
		free_entries < thresh |=> !low_level)
		else $error("low-level flag stuck high");

	// A full FIFO has no free entries, so the flag is low for any threshold
	AST_LOW_FULL: assert property (@(posedge core_clk_in) disable iff (reset_in)
		fifo_level_in == 5'(DEPTH) |=> !low_level)
		else $error("low-level flag high on full FIFO");

	// Status word carries the low-level flag one cycle later
	AST_LOW_STATUS: assert property (@(posedge core_clk_in) disable iff (reset_in)
		low_level |=> tx_fifo_status_out[tx_status_pkg::LOW_LEVEL_BIT])
		else $error("status low-level bit missing");

	// Status word drops the low-level bit with the flag
	AST_LOW_STATUS_OFF: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!low_level |=> !tx_fifo_status_out[tx_status_pkg::LOW_LEVEL_BIT])
		else $error("status low-level bit stuck high");

	// Empty FIFO shows as drained two cycles later
	AST_DRAINED: assert property (@(posedge core_clk_in) disable iff (reset_in)
		fifo_level_in == 5'h00 |=> ##1 tx_fifo_status_out[tx_status_pkg::DRAINED_BIT])
		else $error("drained flag wrong");

	// Any stored entry clears the drained bit two cycles later
	AST_NOT_DRAINED: assert property (@(posedge core_clk_in) disable iff (reset_in)
		fifo_level_in != 5'h00 |=> ##1 !tx_fifo_status_out[tx_status_pkg::DRAINED_BIT])
		else $error("drained flag high with entries");

	// No overflow interrupt without the flag and its enable
	AST_IRQ: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!(overflow && tx_control_reg_in[tx_status_pkg::CTRL_OVER_IE]) |=> !overflow_irq_out)
		else $error("overflow interrupt without enable");

	// Enabled overflow raises the interrupt one cycle later
	AST_IRQ_SET: assert property (@(posedge core_clk_in) disable iff (reset_in)
		overflow && tx_control_reg_in[tx_status_pkg::CTRL_OVER_IE] |=> overflow_irq_out)
		else $error("overflow interrupt missing");

	// Enabled low-level condition raises the transfer request
	AST_DMA: assert property (@(posedge core_clk_in) disable iff (reset_in)
		low_level && tx_control_reg_in[tx_status_pkg::CTRL_DMA_EN] |=> dma_request_out)
		else $error("dma request missing");

	// No transfer request without the condition and its enable
	AST_DMA_OFF: assert property (@(posedge core_clk_in) disable iff (reset_in)
		!(low_level && tx_control_reg_in[tx_status_pkg::CTRL_DMA_EN]) |=> !dma_request_out)
		else $error("dma request without cause");

	// Upper status bits always read zero
	AST_RESERVED: assert property (@(posedge core_clk_in) disable iff (reset_in)
		tx_fifo_status_out[31:4] == 28'h0000000)
		else $error("reserved bits not zero");
endmodule

// [rtl/tx_status_pkg.sv]
// Constants and types for the transmit FIFO status register block
package tx_status_pkg;
	localparam logic [7:0]  STATUS_OFFSET   = 8'h24;
	localparam int          OVERFLOW_BIT    = 3;
	localparam int          STARVE_BIT      = 2;
	localparam int          LOW_LEVEL_BIT   = 1;
	localparam int          DRAINED_BIT     = 0;
	localparam int          CTRL_THRESH_LSB = 8;
	localparam int          CTRL_THRESH_MSB = 11;
	localparam int          CTRL_OVER_IE    = 5;
	localparam int          CTRL_DMA_EN     = 3;
	localparam int          CTRL_FIFO_EN    = 0;
	localparam int          FIFO_DEPTH      = 16;
	localparam logic [31:0] STATUS_RESET    = 32'h0000_0003;

	// Host register access to the status word
	typedef struct packed {
		logic       sel;
		logic       write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} reg_access_t;
endpackage

// [bench/fifo_model.sv]
// Fill-level model of the transmit FIFO storage
`timescale 1ns/1ps
module fifo_model (
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic       push_in,
	input  wire logic       pop_in,
	output logic            full_out,
	output logic [4:0]      level_out
);
	// Count entries; refuse pushes when full and pops when empty
	always_ff @(posedge clk_in or posedge reset_in)
		if (reset_in)
			level_out <= 5'h00;
		else
			level_out <= level_out + 5'(push_in && !full_out) - 5'(pop_in && level_out != 5'h00);
	assign full_out = (level_out == 5'h10);
endmodule

// [bench/tb.sv]
// Self-checking bench for the transmit FIFO status block
`timescale 1ns/1ps
module tb;
	logic                       core_clk_in = 0, reset_in = 1, wr = 0, req = 0, full, irq, dma;
	logic [4:0]                 lvl;
	logic [31:0]                ctrl = 0, st;
	tx_status_pkg::reg_access_t acc = '0;
	logic [33:0]                eq[$];
	int                         due[$], cyc = 0, err_total = 0, compares = 0, th, n;
	int                         seed = 32'heca25adb;
	always #2 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) cyc <= cyc + 1;
	fifo_model m (.clk_in(core_clk_in), .reset_in(reset_in), .push_in(wr), .pop_in(req),
		.full_out(full), .level_out(lvl));
	audio_tx_fifo_status dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .reg_in(acc),
		.fifo_write_in(wr), .fifo_full_in(full), .fifo_level_in(lvl), .sample_request_in(req),
		.tx_control_reg_in(ctrl), .tx_fifo_status_out(st), .overflow_irq_out(irq),
		.dma_request_out(dma));
	task chk(input logic [33:0] seen, input logic [33:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] dma_irq_status exp %h seen %h", exp, seen);
		end
	endtask
	// Queue an expectation, then let outputs settle
	task note(input logic [33:0] exp);
		eq.push_back(exp);
		due.push_back(cyc + 3);
		repeat (5) @(posedge core_clk_in) #1;
	endtask
	task hostw(input logic [7:0] a, input logic [31:0] d);
		acc <= '{1'b1, 1'b1, a, d};
		@(posedge core_clk_in) #1;
		acc <= '0;
		@(posedge core_clk_in) #1;
	endtask
	task pulse(input bit w, input int k);
		repeat (k)
		begin
			wr <= w;
			req <= !w;
			@(posedge core_clk_in) #1;
		end
		wr <= 0;
		req <= 0;
	endtask
	// Compare the oldest due note with the settled outputs
	always @(negedge core_clk_in)
		if (due.size() != 0 && cyc >= due[0])
		begin
			chk({dma, irq, st}, eq.pop_front());
			void'(due.pop_front());
		end
	initial
	begin
		repeat (12) @(posedge core_clk_in);
		#1 reset_in = 0;
		note(34'h0_0000_0003);
		th = $unsigned($random(seed)) % 16; // Zero code stands for sixteen
		n = 1 + $unsigned($random(seed)) % 15;
		ctrl = {20'h0, 4'(th), 8'h21};
		pulse(1, n);
		note({32'h0, 1'((16 - n) >= ((th == 0) ? 16 : th)), 1'b0});
		pulse(1, 17 - n);
		note({2'b01, 32'h8});
		hostw(8'h28, 32'hC);
		hostw(tx_status_pkg::STATUS_OFFSET, 32'h0);
		note({2'b01, 32'h8});
		hostw(tx_status_pkg::STATUS_OFFSET, 32'h8);
		note(34'h0);
		ctrl = ctrl | 32'h8;
		pulse(0, 17);
		note({2'b10, 32'h7});
		hostw(tx_status_pkg::STATUS_OFFSET, 32'h4);
		note({2'b10, 32'h3});
		// Starvation set and clear in one cycle: the set wins
		acc <= '{1'b1, 1'b1, tx_status_pkg::STATUS_OFFSET, 32'h4};
		pulse(0, 1);
		acc <= '0;
		note({2'b10, 32'h7});
		hostw(tx_status_pkg::STATUS_OFFSET, 32'h4);
		// FIFO disabled: neither error flag may rise
		ctrl = ctrl & 32'hFFFF_FFFE;
		pulse(0, 1);
		note({2'b10, 32'h3});
		pulse(1, 17);
		note({2'b00, 32'h0});
		// Overflow with its interrupt enable off
		ctrl = (ctrl | 32'h1) & 32'hFFFF_FFDF;
		pulse(1, 1);
		note({2'b00, 32'h8});
		hostw(tx_status_pkg::STATUS_OFFSET, 32'h8);
		note(34'h0);
		for (int i = 0; i < 20 && due.size() != 0; i++)
			@(posedge core_clk_in);
		if (due.size() != 0)
			err_total++;
		summarize();
	end
	task summarize();
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
endmodule
